// File: core/lsw_regs.svh
`ifndef LSW_REGS_SVH
`define LSW_REGS_SVH
`define LSW_CLK_HZ 40000000
`define LSW_MS_CYC (`LSW_CLK_HZ / 1000)
`define LSW_US_CYC (`LSW_CLK_HZ / 1000000)
`define LSW_FRAME_BITS 5'd16
`define LSW_ADDR_CFG 4'h0
`define LSW_ADDR_DUTY0 4'h1
`define LSW_CFG_PWM_EN 0
`define LSW_CFG_CLK_SEL 1
`define LSW_CFG_COOL_LSB 2
`define LSW_CFG_HEAVY_LSB 4
`define LSW_CFG_RESET 12'h002
`define LSW_DUTY_FULL 8'hff
`define LSW_WDOG_MS 310
`define LSW_TOGGLE_MS 250
`define LSW_CAL_MIN_US 20
`define LSW_CAL_MAX_US 200
`define LSW_CAL_SHIFT 2
`define LSW_PWM_HZ 120
`define LSW_PWM_STEPS 256
`define LSW_PWM_DIV (`LSW_CLK_HZ / (`LSW_PWM_HZ * `LSW_PWM_STEPS))
`define LSW_FAIL_LOW_HZ 4000
`define LSW_FAIL_HIGH_HZ 100000
`define LSW_FAIL_SLOW_CYC (`LSW_CLK_HZ / `LSW_FAIL_LOW_HZ)
`define LSW_FAIL_FAST_CYC (`LSW_CLK_HZ / `LSW_FAIL_HIGH_HZ)
`define LSW_BC1_LIGHT_MS 347
`define LSW_BC2_LIGHT_MS 181
`define LSW_BC1_HEAVY_MS 417
`define LSW_BC2_HEAVY_MS 224
`define LSW_COOL_FAST 2'b01
`define LSW_COOL_SLOW 2'b10
`endif

// File: core/lsw_pkg.sv
package lsw_pkg;
   typedef enum logic [2:0] {
      LSW_SLEEP = 3'b001,
      LSW_RUN = 3'b010,
      LSW_SAFE = 3'b100
   } lsw_mode_t;

   typedef struct packed {
      lsw_mode_t mode;
      logic cs_d;
      logic sclk_d;
      logic rst_d;
      logic [3:0] in_d;
      logic [15:0] shift;
      logic [4:0] bitcnt;
      logic [13:0] cs_len;
      logic sdo;
      logic sdo_oe_n;
      logic flt_oe_n;
      logic [11:0] cfg;
      logic [31:0] duty;
      logic [11:0] div;
      logic [11:0] divcnt;
      logic [7:0] pwmcnt;
      logic [15:0] per;
      logic clk_fail;
      logic wd_run;
      logic [23:0] wd_cnt;
      logic wd_exp;
      logic [23:0] tog_cnt;
      logic tog_to;
      logic [3:0] outs;
      logic [15:0] ms_cnt;
      logic ms_tick;
   } lsw_ctrl_st_t;

   typedef struct packed {
      logic lamp_d;
      logic [1:0] phase;
      logic [10:0] cnt;
   } lsw_cool_st_t;
endpackage

// File: core/lsw_sync.sv
`timescale 1ns/1ps
module lsw_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lsw_sync_st_t;
   lsw_sync_st_t r, n;

   always_comb begin
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;
endmodule // lsw_sync

// File: core/lsw_cool.sv
`timescale 1ns/1ps
`include "lsw_regs.svh"
module lsw_cool import lsw_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ms_tick,
   input wire logic lamp_on,
   input wire logic heavy,
   input wire logic [1:0] sel,
   output logic active
);
   lsw_cool_st_t r, n;
   logic [10:0] base;
   logic [10:0] len;

   always_comb begin
      n = r;
      n.lamp_d = lamp_on;
      // Heavy lamps use the longer step set
      if (r.phase == 2'd1) begin
         base = heavy ? 11'(`LSW_BC1_HEAVY_MS) : 11'(`LSW_BC1_LIGHT_MS);
      end else begin
         base = heavy ? 11'(`LSW_BC2_HEAVY_MS) : 11'(`LSW_BC2_LIGHT_MS);
      end
      // Fast halves, slow doubles, 00 and 11 keep medium
      if (sel == `LSW_COOL_FAST) begin
         len = base >> 1;
      end else if (sel == `LSW_COOL_SLOW) begin
         len = base << 1;
      end else begin
         len = base;
      end
      if (lamp_on) begin
         n.phase = 2'd0;
         n.cnt = '0;
      end else if (r.lamp_d) begin
         n.phase = 2'd1;
         n.cnt = '0;
      end else if (r.phase != 2'd0 && ms_tick) begin
         if (r.cnt >= len - 11'd1) begin
            n.cnt = '0;
            n.phase = (r.phase == 2'd1) ? 2'd2 : 2'd0;
         end else begin
            n.cnt = r.cnt + 11'd1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign active = (r.phase != 2'd0);
endmodule // lsw_cool

// File: core/lsw_ctrl.sv
`timescale 1ns/1ps
`include "lsw_regs.svh"
module lsw_ctrl import lsw_pkg::*; #(
   parameter logic [15:0] MS_CYC = 16'(`LSW_MS_CYC),
   parameter logic [23:0] WDOG_CYC = 24'(`LSW_WDOG_MS * `LSW_MS_CYC),
   parameter logic [23:0] TOGGLE_CYC = 24'(`LSW_TOGGLE_MS * `LSW_MS_CYC),
   parameter logic [13:0] CAL_MAX_CYC = 14'(`LSW_CAL_MAX_US * `LSW_US_CYC),
   parameter logic [15:0] FAIL_SLOW_CYC = 16'(`LSW_FAIL_SLOW_CYC)
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Serial port pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   // Control pins
   input wire logic reset_pin_n,
   input wire logic wake,
   input wire logic [3:0] direct_control_inputs,
   // Fault flag pin
   input wire logic fault_flag_n_in,
   output logic fault_flag_n_out,
   output logic fault_flag_n_oe_n,
   // Power stage side
   output logic [3:0] switched_outputs,
   output logic [3:0] bulb_cooling_active,
   output logic awake
);
   localparam logic [13:0] CAL_MIN_CYC = 14'(`LSW_CAL_MIN_US * `LSW_US_CYC);
   localparam logic [15:0] FAIL_FAST_CYC = 16'(`LSW_FAIL_FAST_CYC);
   localparam logic [11:0] PWM_DIV = 12'(`LSW_PWM_DIV);

   lsw_ctrl_st_t r, n;
   logic [9:0] s;
   logic sclk_s;
   logic cs_s;
   logic sdi_s;
   logic rst_s;
   logic wake_s;
   logic flt_s;
   logic [3:0] in_s;
   logic cs_rise;
   logic cs_fall;
   logic sclk_fall;
   logic rst_rise;
   logic in0_rise;
   logic pwm_en;
   logic clk_int;
   logic tick;
   logic cal_hit;
   logic [3:0] addr;
   logic [3:0] cool_act;
   logic [15:0] status_w;

   // Pin synchronisers
   lsw_sync #(.W(10)) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .d({fault_flag_n_in, direct_control_inputs, wake, reset_pin_n, sdi, ~cs_n, sclk}),
      .q(s)
   );

   assign sclk_s = s[0];
   // Select synced inverted so a cleared synchroniser reads as deselected
   assign cs_s = ~s[1];
   assign sdi_s = s[2];
   assign rst_s = s[3];
   assign wake_s = s[4];
   assign in_s = s[8:5];
   assign flt_s = s[9];

   assign cs_rise = cs_s & ~r.cs_d;
   assign cs_fall = ~cs_s & r.cs_d;
   assign sclk_fall = ~sclk_s & r.sclk_d;
   assign rst_rise = rst_s & ~r.rst_d;
   assign in0_rise = in_s[0] & ~r.in_d[0];
   assign pwm_en = r.cfg[`LSW_CFG_PWM_EN];
   assign clk_int = r.cfg[`LSW_CFG_CLK_SEL];
   assign addr = r.shift[15:12];
   assign cal_hit = cs_rise && r.bitcnt == 5'd0 && r.cs_len >= CAL_MIN_CYC && r.cs_len <= CAL_MAX_CYC;

   // Internal ticks from the divider, external ticks from input zero
   assign tick = clk_int ? (r.divcnt >= r.div - 12'd1) : in0_rise;

   assign status_w = {~flt_s, r.clk_fail, r.wd_exp, r.tog_to, r.outs, cool_act, in_s};

   always_comb begin
      n = r;
      n.cs_d = cs_s;
      n.sclk_d = sclk_s;
      n.rst_d = rst_s;
      n.in_d = in_s;
      n.ms_tick = 1'b0;
      if (r.ms_cnt >= MS_CYC - 16'd1) begin
         n.ms_cnt = '0;
         n.ms_tick = 1'b1;
      end else begin
         n.ms_cnt = r.ms_cnt + 16'd1;
      end

      // Serial shift register; host starts every frame with the clock low
      if (cs_fall) begin
         n.shift = status_w;
         n.bitcnt = '0;
         n.cs_len = '0;
      end else if (!cs_s) begin
         if (r.cs_len != 14'h3fff) begin
            n.cs_len = r.cs_len + 14'd1;
         end
         if (sclk_fall) begin
            n.shift = {r.shift[14:0], sdi_s};
            if (r.bitcnt != 5'h1f) begin
               n.bitcnt = r.bitcnt + 5'd1;
            end
         end
      end
      n.sdo = n.shift[15];
      n.sdo_oe_n = cs_s;

      // Watchdog
      if (rst_rise) begin
         n.wd_run = 1'b1;
         n.wd_cnt = '0;
         n.wd_exp = 1'b0;
      end else if (r.wd_run && !r.wd_exp) begin
         if (r.wd_cnt >= WDOG_CYC - 24'd1) begin
            n.wd_exp = 1'b1;
         end else begin
            n.wd_cnt = r.wd_cnt + 24'd1;
         end
      end

      // Register write or calibration at the end of a frame
      if (cs_rise && r.mode != LSW_SLEEP) begin
         if (r.bitcnt == `LSW_FRAME_BITS) begin
            n.wd_cnt = '0;
            if (addr == `LSW_ADDR_CFG) begin
               n.cfg = r.shift[11:0];
            end
            for (int i = 0; i < 4; i++) begin
               if (addr == `LSW_ADDR_DUTY0 + 4'(i)) begin
                  n.duty[i*8 +: 8] = r.shift[7:0];
               end
            end
         end else if (cal_hit) begin
            n.div = 12'(r.cs_len >> `LSW_CAL_SHIFT);
         end
      end

      // Input toggle timeout
      if (in_s != r.in_d) begin
         n.tog_cnt = '0;
         n.tog_to = 1'b0;
      end else if (!r.tog_to) begin
         if (r.tog_cnt >= TOGGLE_CYC - 24'd1) begin
            n.tog_to = 1'b1;
         end else begin
            n.tog_cnt = r.tog_cnt + 24'd1;
         end
      end

      // PWM time base
      if (!clk_int || tick) begin
         n.divcnt = '0;
      end else begin
         n.divcnt = r.divcnt + 12'd1;
      end
      if (tick && !r.clk_fail) begin
         n.pwmcnt = r.pwmcnt + 8'd1;
      end

      // External clock check
      if (!(pwm_en && !clk_int && r.mode == LSW_RUN)) begin
         n.per = '0;
         n.clk_fail = 1'b0;
      end else if (in0_rise) begin
         n.clk_fail = r.per >= FAIL_SLOW_CYC || r.per <= FAIL_FAST_CYC;
         n.per = '0;
      end else if (r.per < FAIL_SLOW_CYC) begin
         n.per = r.per + 16'd1;
      end else begin
         n.clk_fail = 1'b1;
      end

      // Output drive
      for (int i = 0; i < 4; i++) begin
         if (r.mode == LSW_SLEEP) begin
            n.outs[i] = 1'b0;
         end else if (r.mode == LSW_RUN && pwm_en) begin
            n.outs[i] = r.duty[i*8 +: 8] == `LSW_DUTY_FULL || r.pwmcnt < r.duty[i*8 +: 8];
         end else begin
            n.outs[i] = in_s[i];
         end
      end

      n.flt_oe_n = ~(r.clk_fail | r.wd_exp);

      // Operating mode
      unique case (r.mode)
         LSW_SLEEP: begin
            if (rst_s && (rst_rise || wake_s || |in_s)) begin
               n.mode = LSW_RUN;
            end
         end
         LSW_RUN: begin
            if (r.wd_exp) begin
               n.mode = LSW_SAFE;
            end
         end
         LSW_SAFE: begin
            n.mode = LSW_SAFE;
         end
         default: begin
            n.mode = LSW_SLEEP;
         end
      endcase

      if (!rst_s) begin
         n.mode = LSW_SLEEP;
         n.cfg = `LSW_CFG_RESET;
         n.duty = '0;
         n.div = PWM_DIV;
         n.clk_fail = 1'b0;
         n.wd_run = 1'b0;
         n.wd_exp = 1'b0;
         n.tog_to = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r <= '0;
         r.mode <= LSW_SLEEP;
         r.cs_d <= 1'b1;
         r.sdo_oe_n <= 1'b1;
         r.flt_oe_n <= 1'b1;
         r.cfg <= `LSW_CFG_RESET;
         r.div <= PWM_DIV;
      end else begin
         r <= n;
      end
   end

   // Cooling timers, one per output
   for (genvar g = 0; g < 4; g++) begin : g_cool
      lsw_cool u_cool (
         .clk_sys(clk_sys),
         .reset(reset),
         .ms_tick(r.ms_tick),
         .lamp_on(r.outs[g]),
         .heavy(g >= 2 ? 1'b1 : r.cfg[`LSW_CFG_HEAVY_LSB + g]),
         .sel(r.cfg[`LSW_CFG_COOL_LSB +: 2]),
         .active(cool_act[g])
      );
   end

   assign sdo_out = r.sdo;
   assign sdo_oe_n = r.sdo_oe_n;
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe_n = r.flt_oe_n;
   assign switched_outputs = r.outs;
   assign bulb_cooling_active = cool_act;
   assign awake = (r.mode != LSW_SLEEP);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_sdo_float: assert property (cs_s |=> sdo_oe_n)
      else $error("serial output driven while deselected");
   a_sdo_msb: assert property (cs_fall |=> !sdo_oe_n && sdo_out == $past(status_w[15]))
      else $error("first output bit is not the status MSB");
   a_status_load: assert property (cs_fall |=> r.shift == $past(status_w))
      else $error("status not loaded at select");
   a_cfg_latch: assert property (cs_rise && rst_s && r.mode != LSW_SLEEP && r.bitcnt == 5'd16
      && addr == `LSW_ADDR_CFG |=> r.cfg == $past(r.shift[11:0]))
      else $error("configuration not latched");
   a_short_frame: assert property (cs_rise && rst_s && r.bitcnt != 5'd16 |=> $stable(r.cfg))
      else $error("short frame changed configuration");
   a_sdi_sample: assert property (!cs_s && !r.cs_d && sclk_fall |=> r.shift[0] == $past(sdi_s))
      else $error("input bit not sampled on falling clock");
   a_sleep_clear: assert property (!rst_s |=> r.mode == LSW_SLEEP && r.cfg == `LSW_CFG_RESET)
      else $error("reset pin low did not clear and sleep");
   a_wdog_start: assert property (rst_rise |=> r.wd_run && r.wd_cnt == 24'd0 && !r.wd_exp)
      else $error("watchdog not started by reset pin");
   a_wdog_expire: assert property (rst_s && r.wd_run && r.wd_cnt == WDOG_CYC - 24'd1 && !cs_rise
      |=> r.wd_exp ##1 !fault_flag_n_oe_n)
      else $error("watchdog did not expire on time");
   a_direct_path: assert property (r.mode == LSW_RUN && !pwm_en |=> switched_outputs == $past(in_s))
      else $error("output does not follow direct input");
   a_full_duty: assert property (r.mode == LSW_RUN && pwm_en && r.duty[7:0] == `LSW_DUTY_FULL
      |=> switched_outputs[0])
      else $error("full duty output not on");
   a_fault_pin: assert property (r.clk_fail || r.wd_exp |=> !fault_flag_n_oe_n)
      else $error("fault not shown on flag pin");

   c_frame: cover property (cs_rise && r.bitcnt == 5'd16);
   c_calib: cover property (cal_hit && r.mode != LSW_SLEEP);
   c_clk_fail: cover property (r.clk_fail);
   c_wdog: cover property (r.wd_exp);
endmodule // lsw_ctrl

// File: bench/lsw_host.sv
`timescale 1ns/1ps
module lsw_host (
   // Clock
   input wire logic clk_sys,
   // Serial port
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   // Control pins
   output logic reset_pin_n,
   output logic wake,
   output logic [3:0] direct_control_inputs
);
   logic alt = 1'b0;
   logic sdo_w;

   // Floating data line seen as a changing pattern
   always @(posedge clk_sys) begin
      alt <= ~alt;
   end
   assign sdo_w = sdo_oe_n ? alt : sdo_out;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      reset_pin_n = 1'b0;
      wake = 1'b0;
      direct_control_inputs = 4'h0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Pin held low 400 clk, 10 us
   task automatic pin_reset();
      tick(1);
      reset_pin_n <= 1'b0;
      tick(400);
      reset_pin_n <= 1'b1;
   endtask

   // Top n bits of tx, serial clock 225 ns, capture on falling edge
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      tick(1);
      cs_n <= 1'b0;
      tick(6);
      for (int i = 15; i > 15 - n; i--) begin
         sdi <= tx[i];
         tick(4);
         sclk <= 1'b1;
         tick(3);
         @(negedge clk_sys);
         rx = {rx[14:0], sdo_w};
         tick(1);
         sclk <= 1'b0;
         // Hold data one cycle past the falling clock
         tick(1);
      end
      tick(4);
      cs_n <= 1'b1;
      tick(8);
   endtask

   // External PWM clock on input zero
   task automatic ext_clk(input int half, input int n);
      repeat (n) begin
         tick(half);
         direct_control_inputs[0] <= 1'b1;
         tick(half);
         direct_control_inputs[0] <= 1'b0;
      end
   endtask
endmodule // lsw_host

// File: bench/lsw_ctrl_test.sv
`timescale 1ns/1ps
module lsw_ctrl_test;
   localparam int MS = 40;
   localparam int WD = 8000;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo_out;
   logic sdo_oe_n;
   logic reset_pin_n;
   logic wake;
   logic [3:0] direct_control_inputs;
   logic fault_flag_n_in;
   logic fault_flag_n_out;
   logic fault_flag_n_oe_n;
   logic [3:0] switched_outputs;
   logic [3:0] bulb_cooling_active;
   logic awake;
   logic [15:0] rx;
   int bad_count = 0;
   int samples_checked = 0;

   always #12.5 clk_sys = ~clk_sys;
   // Pull-up on the fault line
   assign fault_flag_n_in = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_out;

   lsw_ctrl #(.MS_CYC(16'd40), .WDOG_CYC(24'd8000), .TOGGLE_CYC(24'd1000), .FAIL_SLOW_CYC(16'd1000)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .reset_pin_n(reset_pin_n), .wake(wake),
      .direct_control_inputs(direct_control_inputs), .fault_flag_n_in(fault_flag_n_in),
      .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe_n(fault_flag_n_oe_n),
      .switched_outputs(switched_outputs), .bulb_cooling_active(bulb_cooling_active), .awake(awake));

   lsw_host u_host (
      .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .reset_pin_n(reset_pin_n), .wake(wake),
      .direct_control_inputs(direct_control_inputs));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic s_sleep();
      u_host.wake <= 1'b1;
      tick(20);
      chk("awake in reset", awake, 0);
      chk("outputs in reset", switched_outputs, 0);
      u_host.pin_reset();
      u_host.wake <= 1'b0;
      tick(8);
      chk("awake after pin rise", awake, 1);
   endtask

   task automatic s_watchdog();
      tick(WD - 120);
      chk("fault early", fault_flag_n_oe_n, 1);
      tick(240);
      chk("fault on expiry", fault_flag_n_oe_n, 0);
      u_host.frame(16'h0002, 16, rx);
      chk("status flags", {rx[15], rx[14], rx[13]}, 3'b101);
      chk("toggle timeout", rx[12], 1);
      u_host.pin_reset();
      tick(8);
      chk("fault after pin reset", fault_flag_n_oe_n, 1);
   endtask

   task automatic s_direct();
      u_host.direct_control_inputs <= 4'ha;
      tick(8);
      chk("direct outputs", switched_outputs, 4'ha);
      fork
         u_host.frame(16'h0002, 16, rx);
         begin
            tick(10);
            chk("sdo enable in frame", sdo_oe_n, 0);
         end
      join
      chk("sdo enable idle", sdo_oe_n, 1);
      chk("status outputs", rx[11:8], 4'ha);
      chk("status inputs", rx[3:0], 4'ha);
      u_host.cs_n <= 1'b0;
      tick(1000);
      u_host.cs_n <= 1'b1;
      tick(8);
      chk("calibrated divider", u_dut.r.div >= 12'd245 && u_dut.r.div <= 12'd255, 1);
   endtask

   task automatic s_pwm();
      u_host.direct_control_inputs <= 4'b0010;
      u_host.frame(16'h10ff, 16, rx);
      u_host.frame(16'h2000, 16, rx);
      u_host.frame(16'h0003, 16, rx);
      tick(20);
      chk("full and zero duty", switched_outputs[1:0], 2'b01);
      u_host.frame(16'h0002, 15, rx);
      tick(20);
      chk("short frame", switched_outputs[1:0], 2'b01);
      u_host.frame(16'h0002, 16, rx);
      tick(20);
      chk("pwm off", switched_outputs[1:0], 2'b10);
      u_host.direct_control_inputs <= 4'h0;
   endtask

   task automatic cf(input int half, input logic [11:0] cfg, input logic exp);
      fork
         u_host.ext_clk(half, 6000 / (2 * half));
         repeat (3) begin
            tick(1500);
            u_host.frame({4'h0, cfg}, 16, rx);
         end
      join
      chk("clock fail", rx[14], exp);
   endtask

   task automatic cool(input logic [1:0] code, input int lt, input int hv);
      int n0;
      int n2;
      n0 = 0;
      n2 = 0;
      u_host.pin_reset();
      tick(10);
      u_host.frame({12'h000, code, 2'b10}, 16, rx);
      u_host.direct_control_inputs <= 4'b0101;
      tick(20);
      u_host.direct_control_inputs <= 4'h0;
      repeat (hv * 23 / 20) begin
         tick(MS);
         n0 += bulb_cooling_active[0];
         n2 += bulb_cooling_active[2];
      end
      chk("light cooling", n0 >= lt * 9 / 10 && n0 <= lt * 11 / 10, 1);
      chk("heavy cooling", n2 >= hv * 9 / 10 && n2 <= hv * 11 / 10, 1);
   endtask

   initial begin
      tick(16);
      reset <= 1'b0;
   end

   initial begin
      tick(110000);
      bad_count++;
      end_sim();
   end

   initial begin
      tick(18);
      s_sleep();
      s_watchdog();
      s_direct();
      s_pwm();
      cf(300, 12'h001, 1'b0);
      cf(600, 12'h001, 1'b1);
      cf(600, 12'h003, 1'b0);
      cf(100, 12'h001, 1'b1);
      cool(2'b01, 263, 321);
      cool(2'b11, 528, 641);
      end_sim();
   end
endmodule // lsw_ctrl_test
